/* core/tmr_pkg.sv */
// Package for the 8-bit timer/counter: register map, field positions, timing constants.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package tmr_pkg;
  localparam int unsigned ADDR_W = 6;
  // Register byte addresses
  localparam logic [5:0] OFS_CTRL_A   = 6'h00;
  localparam logic [5:0] OFS_COUNT    = 6'h04;
  localparam logic [5:0] OFS_COMPARE  = 6'h08;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h0C;
  localparam logic [5:0] OFS_IRQ_FLAG = 6'h10;
  localparam logic [5:0] OFS_GEN_CTRL = 6'h14;
  localparam logic [5:0] OFS_IRQ_CLR  = 6'h18;
  // Field positions
  localparam int unsigned BIT_FORCE   = 7;
  localparam int unsigned BIT_WGM1    = 6;
  localparam int unsigned BIT_WGM0    = 3;
  localparam int unsigned CS_LSB      = 0;
  localparam int unsigned BIT_CMP     = 1;
  localparam int unsigned BIT_OVF     = 0;
  localparam int unsigned BIT_SYNC    = 7;
  localparam int unsigned BIT_SECOND_PRESCALER_RESET    = 1;
  localparam int unsigned BIT_SHARED_PRESCALER_RESET   = 0;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Prescaler taps (count of io_clock cycles minus one)
  localparam logic [9:0] PRE_MAX    = 10'h3FF;
  localparam logic [9:0] MASK_8     = 10'h007;
  localparam logic [9:0] MASK_64    = 10'h03F;
  localparam logic [9:0] MASK_256   = 10'h0FF;
  localparam logic [9:0] MASK_1024  = 10'h3FF;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Waveform generation modes
  typedef enum logic [1:0] {
    TMR_NORMAL = 2'h0,
    TMR_PC_PWM = 2'h1,
    TMR_CTC    = 2'h2,
    TMR_FAST   = 2'h3
  } tmr_wgm_e;
  // Flag pair carried together
  typedef struct packed {
    logic cmp;
    logic ovf;
  } tmr_flags_s;
endpackage

/* core/tmr_timer0.sv */
// 8-bit timer/counter control and status core with AXI4-Lite register access.
// Assumes a synchronous bus master on clk; external_count_pin is asynchronous.
// Function
// RULE1: A three-bit clock select picks stop, io_clock divided by 1, 8, 64, 256, 1024, or the external pin falling or rising edge.
// RULE2: External pin edges advance the counter whatever the pin direction is.
// RULE3: The count register is directly readable and writable by software.
// RULE4: A software write to the count suppresses a compare match on the next timer clock.
// RULE5: The compare value is compared with the count continuously.
// RULE6: The compare enable in mask bit 1 with the global enable gates the compare interrupt.
// RULE7: The overflow enable in mask bit 0 with the global enable gates the overflow interrupt.
// RULE8: The compare flag in flag bit 1 sets on match and clears on vector entry or a written one.
// RULE9: The overflow flag in flag bit 0 sets on overflow and clears on vector entry or a written one.
// RULE10: In phase correct mode the overflow flag sets when the counter turns at zero.
// RULE11: With sync mode bit 7 set, the prescaler reset bits keep their written values.
// RULE12: Writing sync mode to zero clears both prescaler reset bits so held timers start together.
// RULE13: The shared prescaler reset bit 0 resets the prescaler and self-clears unless sync mode is on.
// RULE14: An external pin edge reaches the counter after synchronising and edge detection.
// RULE15: The force-compare strobe reads zero and forces a compare action without flag or clear.
// RULE16: Writing zero to a flag leaves it unchanged; ones on clear flags do nothing.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module tmr_timer0 (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_count_pin,
  input  wire logic        global_irq_enable,
  input  wire logic        compare_vector_ack,
  input  wire logic        overflow_vector_ack,
  output logic             compare_output_pin,
  output logic             irq,
  output logic             compare_irq,
  output logic             overflow_irq
);
  // Control registers
  logic [7:0] control_reg_a;
  logic [7:0] count_value_reg;
  logic [7:0] compare_value_reg;
  logic [7:0] interrupt_mask_reg;
  logic       sync_hold_mode;
  logic       shared_prescaler_reset;
  logic       second_prescaler_reset;
  tmr_pkg::tmr_flags_s flags;
  logic [9:0] prescale;
  logic       count_down;
  logic       block_match;
  logic       cmp_state;
  // Pin synchroniser
  logic       pin_s1;
  logic       pin_s2;
  logic       pin_s3;
  // Bus state
  logic       aw_held;
  logic       w_held;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_fire;
  logic       wr_lane0;
  logic [7:0] wbyte;
  logic [2:0] count_clock_select;
  tmr_pkg::tmr_wgm_e wgm;
  logic       tick;
  logic       ext_rise;
  logic       ext_fall;
  logic       cnt_wr;
  logic       match;
  logic       ovf_event;
  logic       cmp_event;
  logic       force_compare_strobe;
  logic [7:0] next_count;
  logic       next_down;
  logic [7:0] rd_byte;
  logic       rd_hit;

  assign count_clock_select = control_reg_a[tmr_pkg::CS_LSB +: 3];
  assign wgm = tmr_pkg::tmr_wgm_e'({control_reg_a[tmr_pkg::BIT_WGM1],
                                    control_reg_a[tmr_pkg::BIT_WGM0]});
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && w_strb[0];
  assign wbyte    = w_data[7:0];
  assign cnt_wr   = wr_lane0 && (aw_addr == tmr_pkg::OFS_COUNT);
  assign force_compare_strobe = wr_lane0 && (aw_addr == tmr_pkg::OFS_CTRL_A)
                                && wbyte[tmr_pkg::BIT_FORCE];

  // Two flops then an edge register; second and third stages feed the detector
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= external_count_pin; // RULE2
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  assign ext_rise = pin_s2 && !pin_s3; // RULE14
  assign ext_fall = !pin_s2 && pin_s3; // RULE14

  // Shared prescaler, held in reset while the reset bit is high
  always_ff @(posedge clk) begin
    if (sys_rst || shared_prescaler_reset) begin
      prescale <= '0; // RULE13
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  always_comb begin
    tick = 1'b0;
    case (count_clock_select) // RULE1
      tmr_pkg::CS_STOP:     tick = 1'b0;
      tmr_pkg::CS_DIV1:     tick = 1'b1;
      tmr_pkg::CS_DIV8:     tick = (prescale & tmr_pkg::MASK_8) == tmr_pkg::MASK_8;
      tmr_pkg::CS_DIV64:    tick = (prescale & tmr_pkg::MASK_64) == tmr_pkg::MASK_64;
      tmr_pkg::CS_DIV256:   tick = (prescale & tmr_pkg::MASK_256) == tmr_pkg::MASK_256;
      tmr_pkg::CS_DIV1024:  tick = (prescale & tmr_pkg::MASK_1024) == tmr_pkg::MASK_1024;
      tmr_pkg::CS_EXT_FALL: tick = ext_fall;
      tmr_pkg::CS_EXT_RISE: tick = ext_rise;
      default:              tick = 1'b0;
    endcase
    // Internal sources are gated by the prescaler reset, which halts the timer
    if (shared_prescaler_reset && count_clock_select != tmr_pkg::CS_EXT_FALL
        && count_clock_select != tmr_pkg::CS_EXT_RISE) begin
      tick = 1'b0;
    end
  end

  assign match = (count_value_reg == compare_value_reg); // RULE5
  assign cmp_event = tick && match && !block_match;      // RULE4

  // Counting sequence per waveform mode
  always_comb begin
    next_count = count_value_reg;
    next_down  = count_down;
    ovf_event  = 1'b0;
    case (wgm)
      tmr_pkg::TMR_PC_PWM: begin
        if (count_down) begin
          if (count_value_reg == tmr_pkg::CNT_BOTTOM) begin
            next_down  = 1'b0;
            next_count = count_value_reg + 8'h01;
            ovf_event  = 1'b1; // RULE10
          end else begin
            next_count = count_value_reg - 8'h01;
          end
        end else if (count_value_reg == tmr_pkg::CNT_MAX) begin
          next_down  = 1'b1;
          next_count = count_value_reg - 8'h01;
        end else begin
          next_count = count_value_reg + 8'h01;
        end
      end
      tmr_pkg::TMR_CTC: begin
        if (match) begin
          next_count = tmr_pkg::CNT_BOTTOM;
        end else begin
          next_count = count_value_reg + 8'h01;
        end
        ovf_event = (count_value_reg == tmr_pkg::CNT_MAX);
      end
      default: begin
        next_count = count_value_reg + 8'h01;
        ovf_event  = (count_value_reg == tmr_pkg::CNT_MAX);
      end
    endcase
  end

  // Counter; a software write has priority over counting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_value_reg <= tmr_pkg::RST_BYTE;
      count_down      <= 1'b0;
    end else if (cnt_wr) begin
      count_value_reg <= wbyte; // RULE3
    end else if (tick) begin
      count_value_reg <= next_count;
      count_down      <= next_down;
    end
  end

  // Match blocking lasts until the next timer clock, even while stopped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      block_match <= 1'b0;
    end else if (cnt_wr) begin
      block_match <= 1'b1; // RULE4
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // Compare output toggles on match or on a forced compare
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp_state <= 1'b0;
    end else if (cmp_event || force_compare_strobe) begin
      cmp_state <= !cmp_state; // RULE15
    end
  end

  // Flags: set wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= '0;
    end else begin
      if (cmp_event) begin
        flags.cmp <= 1'b1; // RULE8
      end else if (compare_vector_ack) begin
        flags.cmp <= 1'b0; // RULE8
      end else if (wr_lane0 && wbyte[tmr_pkg::BIT_CMP] &&
                   (aw_addr == tmr_pkg::OFS_IRQ_FLAG || aw_addr == tmr_pkg::OFS_IRQ_CLR)) begin
        flags.cmp <= 1'b0; // RULE16
      end
      if (tick && ovf_event) begin
        flags.ovf <= 1'b1; // RULE9
      end else if (overflow_vector_ack) begin
        flags.ovf <= 1'b0; // RULE9
      end else if (wr_lane0 && wbyte[tmr_pkg::BIT_OVF] &&
                   (aw_addr == tmr_pkg::OFS_IRQ_FLAG || aw_addr == tmr_pkg::OFS_IRQ_CLR)) begin
        flags.ovf <= 1'b0; // RULE16
      end
    end
  end

  // Control, compare and mask registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_reg_a      <= tmr_pkg::RST_BYTE;
      compare_value_reg  <= tmr_pkg::RST_BYTE;
      interrupt_mask_reg <= tmr_pkg::RST_BYTE;
    end else if (wr_lane0) begin
      case (aw_addr)
        tmr_pkg::OFS_CTRL_A: begin
          control_reg_a <= {1'b0, wbyte[6:0]}; // RULE15
        end
        tmr_pkg::OFS_COMPARE:  compare_value_reg  <= wbyte;
        tmr_pkg::OFS_IRQ_MASK: interrupt_mask_reg <= wbyte;
        default: begin
        end
      endcase
    end
  end

  // General control: sync mode holds reset bits, else they self-clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_hold_mode         <= 1'b0;
      shared_prescaler_reset <= 1'b0;
      second_prescaler_reset <= 1'b0;
    end else if (wr_lane0 && aw_addr == tmr_pkg::OFS_GEN_CTRL) begin
      sync_hold_mode         <= wbyte[tmr_pkg::BIT_SYNC];
      // One cycle of reset follows a reset bit written as one; it stays only under sync mode
      shared_prescaler_reset <= wbyte[tmr_pkg::BIT_SHARED_PRESCALER_RESET]; // RULE11
      second_prescaler_reset <= wbyte[tmr_pkg::BIT_SECOND_PRESCALER_RESET];  // RULE11
    end else if (!sync_hold_mode) begin
      shared_prescaler_reset <= 1'b0; // RULE12 RULE13
      second_prescaler_reset <= 1'b0; // RULE12
    end
  end

  // Interrupt outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      compare_irq  <= 1'b0;
      overflow_irq <= 1'b0;
      irq          <= 1'b0;
    end else begin
      compare_irq  <= global_irq_enable && interrupt_mask_reg[tmr_pkg::BIT_CMP]
                      && flags.cmp; // RULE6
      overflow_irq <= global_irq_enable && interrupt_mask_reg[tmr_pkg::BIT_OVF]
                      && flags.ovf; // RULE7
      irq          <= global_irq_enable &&
                      ((interrupt_mask_reg[tmr_pkg::BIT_CMP] && flags.cmp) ||
                       (interrupt_mask_reg[tmr_pkg::BIT_OVF] && flags.ovf));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      compare_output_pin <= 1'b0;
    end else begin
      compare_output_pin <= cmp_state;
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tmr_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > tmr_pkg::OFS_IRQ_CLR || aw_addr[1:0] != 2'h0) ?
                        tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode
  always_comb begin
    rd_byte = tmr_pkg::RST_BYTE;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      tmr_pkg::OFS_CTRL_A:   rd_byte = control_reg_a; // RULE15
      tmr_pkg::OFS_COUNT:    rd_byte = count_value_reg; // RULE3
      tmr_pkg::OFS_COMPARE:  rd_byte = compare_value_reg;
      tmr_pkg::OFS_IRQ_MASK: rd_byte = interrupt_mask_reg;
      tmr_pkg::OFS_IRQ_FLAG: rd_byte = {6'h00, flags};
      tmr_pkg::OFS_GEN_CTRL: rd_byte = {sync_hold_mode, 5'h00,
                                        second_prescaler_reset, shared_prescaler_reset};
      tmr_pkg::OFS_IRQ_CLR:  rd_byte = tmr_pkg::RST_BYTE;
      default:               rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= tmr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b0 :
                       (!s_axi_arready && !s_axi_rvalid);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* sim/tmr_timer0_checker.sv */
// Concurrent checks on the timer core ports: bus timing, read-back and interrupt gating.
// Assumes it is bound onto tmr_timer0 and sees only that module's ports.
`timescale 1ns/1ps
module tmr_timer0_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        global_irq_enable,
  input wire logic        irq,
  input wire logic        compare_irq,
  input wire logic        overflow_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken while pending");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken while pending");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_r_time: assert property (p_r_time) else $error("read data late");
  // Unmapped reads must not leak a neighbouring register
  property p_bad_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h18 |->
      ##[1:2] (s_axi_rvalid && s_axi_rresp == tmr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0);
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");
  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_force_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == tmr_pkg::OFS_CTRL_A |->
      ##[1:2] (s_axi_rvalid && !s_axi_rdata[7]);
  endproperty
  a_force_read: assert property (p_force_read) else $error("force strobe reads one");
  property p_irq_or;
    irq == (compare_irq || overflow_irq);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not the or of sources");
  property p_gie_gate;
    compare_irq || overflow_irq |-> $past(global_irq_enable);
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("irq without global enable");
  property p_gie_fall;
    $fell(global_irq_enable) |=> !irq;
  endproperty
  a_gie_fall: assert property (p_gie_fall) else $error("irq outlives global enable");
endmodule

/* sim/tmr_ext_src.sv */
// Model of the external count source that drives the count pin.
// Assumes clk is the io_clock; the pin stands still between bursts.
`timescale 1ns/1ps
module tmr_ext_src (
  input wire logic clk,
  output logic     pin
);
  initial pin = 1'b0;
  // Three cycles per level keeps every half period above one io_clock cycle
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk);
      pin <= 1'b1;
      repeat (3) @(posedge clk);
      pin <= 1'b0;
    end
  endtask
endmodule

/* sim/timer0_clock_flags_prescaler_sync_test.sv */
// Self-checking bench for the timer core: registers, clock select, flags, sync hold.
// Assumes tmr_pkg, tmr_timer0, tmr_ext_src and the checker are compiled before it.
`timescale 1ns/1ps
module timer0_clock_flags_prescaler_sync_test;
  logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, external_count_pin, global_irq_enable;
  logic        compare_vector_ack, overflow_vector_ack, compare_output_pin;
  logic        irq, compare_irq, overflow_irq, p;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  v;
  int          fail_count, num_checks, c, n;

  tmr_timer0 u_dut (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .external_count_pin(external_count_pin), .global_irq_enable(global_irq_enable),
    .compare_vector_ack(compare_vector_ack), .overflow_vector_ack(overflow_vector_ack),
    .compare_output_pin(compare_output_pin), .irq(irq), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq)
  );
  tmr_ext_src u_src (.clk(clk), .pin(external_count_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] x);
    int k;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, x};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (!s_axi_bvalid && k < 64);
    s_axi_bready <= 1'b0;
    if (k == 64) chk(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] x, output logic [1:0] e);
    int k;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (!s_axi_rvalid && k < 64);
    s_axi_rready <= 1'b0;
    x = s_axi_rdata;
    e = s_axi_rresp;
    if (k == 64) chk(32'h0, 32'h1);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] x);
    rd(a, d, r);
    chk(d, {24'h0, x});
  endtask

  // Stop writes also clear the mode bits, which the bench sets only in its final phase correct section
  task automatic run(input logic [2:0] cs, input int cyc);
    wr(tmr_pkg::OFS_CTRL_A, {5'h0, cs});
    repeat (cyc) @(posedge clk);
    wr(tmr_pkg::OFS_CTRL_A, 8'h00);
  endtask

  function automatic int div_of(input int cs);
    return cs == 1 ? 1 : cs == 2 ? 8 : cs == 3 ? 64 : cs == 4 ? 256 : 1024;
  endfunction

  function automatic logic [7:0] exp_gen(input logic [7:0] w);
    return w[7] ? (w & 8'h83) : 8'h00;
  endfunction

  initial begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h1_F & 5'h10;
    {s_axi_rready, global_irq_enable, compare_vector_ack, overflow_vector_ack} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'h1;
    fail_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    void'($urandom(32'hb444_71a8));
    for (c = 0; c < 7; c++) rchk(6'(c * 4), 8'h00);
    rd(6'h1C, d, r);
    chk(r, tmr_pkg::RESP_SLVERR);
    repeat (4) begin
      v = 8'($urandom);
      wr(tmr_pkg::OFS_COUNT, v);
      rchk(tmr_pkg::OFS_COUNT, v);
    end
    // Bus latency widens the window, so the bound is loose only for the undivided and divide-by-8 clocks
    for (c = 1; c < 6; c++) begin
      wr(tmr_pkg::OFS_COUNT, 8'h00);
      run(3'(c), 8 * div_of(c));
      rd(tmr_pkg::OFS_COUNT, d, r);
      chk(d >= 8 && d <= 9 + 16 / div_of(c), 1);
    end
    for (c = 6; c < 8; c++) begin
      n = 1 + $urandom % 6;
      wr(tmr_pkg::OFS_COUNT, 8'h00);
      wr(tmr_pkg::OFS_CTRL_A, 8'(c));
      u_src.pulses(n);
      repeat (6) @(posedge clk);
      wr(tmr_pkg::OFS_CTRL_A, 8'h00);
      rchk(tmr_pkg::OFS_COUNT, 8'(n));
    end
    wr(tmr_pkg::OFS_IRQ_FLAG, 8'h03);
    wr(tmr_pkg::OFS_IRQ_MASK, 8'h03);
    global_irq_enable <= 1'b1;
    p = compare_output_pin;
    v = 8'($urandom % 200) + 8'h10;
    wr(tmr_pkg::OFS_COMPARE, v);
    wr(tmr_pkg::OFS_COUNT, v - 8'd4);
    run(tmr_pkg::CS_DIV1, 4);
    rchk(tmr_pkg::OFS_IRQ_FLAG, 8'h02);
    chk({irq, compare_irq, overflow_irq}, 3'b110);
    chk(compare_output_pin, !p);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk);
    chk({irq, compare_irq}, 2'b00);
    global_irq_enable <= 1'b1;
    wr(tmr_pkg::OFS_IRQ_FLAG, 8'h00);
    rchk(tmr_pkg::OFS_IRQ_FLAG, 8'h02);
    wr(tmr_pkg::OFS_IRQ_FLAG, 8'h02);
    rchk(tmr_pkg::OFS_IRQ_FLAG, 8'h00);
    wr(tmr_pkg::OFS_COUNT, 8'hFC);
    run(tmr_pkg::CS_DIV1, 4);
    rchk(tmr_pkg::OFS_IRQ_FLAG, 8'h01);
    chk({irq, overflow_irq}, 2'b11);
    {overflow_vector_ack, compare_vector_ack} <= 2'b11;
    @(posedge clk);
    {overflow_vector_ack, compare_vector_ack} <= 2'b00;
    rchk(tmr_pkg::OFS_IRQ_FLAG, 8'h00);
    wr(tmr_pkg::OFS_COMPARE, 8'h40);
    wr(tmr_pkg::OFS_COUNT, 8'h40);
    run(tmr_pkg::CS_DIV8, 20);
    rchk(tmr_pkg::OFS_IRQ_FLAG, 8'h00);
    p = compare_output_pin;
    wr(tmr_pkg::OFS_CTRL_A, 8'h80);
    repeat (2) @(posedge clk);
    chk(compare_output_pin, !p);
    rchk(tmr_pkg::OFS_CTRL_A, 8'h00);
    rchk(tmr_pkg::OFS_IRQ_FLAG, 8'h00);
    wr(tmr_pkg::OFS_GEN_CTRL, 8'h83);
    rchk(tmr_pkg::OFS_GEN_CTRL, exp_gen(8'h83));
    wr(tmr_pkg::OFS_COUNT, 8'h00);
    wr(tmr_pkg::OFS_CTRL_A, {5'h0, tmr_pkg::CS_DIV8});
    repeat (40) @(posedge clk);
    rchk(tmr_pkg::OFS_COUNT, 8'h00);
    // Reset bit written high with sync off must be dropped by hardware
    wr(tmr_pkg::OFS_GEN_CTRL, 8'h01);
    rchk(tmr_pkg::OFS_GEN_CTRL, exp_gen(8'h01));
    repeat (40) @(posedge clk);
    rd(tmr_pkg::OFS_COUNT, d, r);
    chk(d != 0, 1);
    wr(tmr_pkg::OFS_CTRL_A, 8'h00);
    wr(tmr_pkg::OFS_GEN_CTRL, 8'h01);
    rchk(tmr_pkg::OFS_GEN_CTRL, exp_gen(8'h01));
    // Phase correct, undivided: no overflow at the top, one when turning at zero
    wr(tmr_pkg::OFS_IRQ_FLAG, 8'h03);
    wr(tmr_pkg::OFS_COUNT, 8'hF0);
    wr(tmr_pkg::OFS_CTRL_A, 8'h09);
    repeat (200) @(posedge clk);
    wr(tmr_pkg::OFS_CTRL_A, 8'h00);
    rd(tmr_pkg::OFS_IRQ_FLAG, d, r);
    chk(d[0], 1'b0);
    wr(tmr_pkg::OFS_CTRL_A, 8'h09);
    repeat (80) @(posedge clk);
    wr(tmr_pkg::OFS_CTRL_A, 8'h00);
    rd(tmr_pkg::OFS_IRQ_FLAG, d, r);
    chk(d[0], 1'b1);
    end_of_test;
  end

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
endmodule

bind tmr_timer0 tmr_timer0_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .global_irq_enable(global_irq_enable), .irq(irq), .compare_irq(compare_irq),
  .overflow_irq(overflow_irq)
);
